// >>> pes_event_regs.vh
// Register map, field layout and reset values of the event controller
`ifndef PES_EVENT_REGS_VH
`define PES_EVENT_REGS_VH

`define PES_ADDR_W 6
`define PES_DATA_W 24
`define PES_OFF_LATCH_A 6'h00
`define PES_OFF_BLOCK_A 6'h01
`define PES_OFF_LIVE_A 6'h02
`define PES_OFF_LATCH_B 6'h03

`define PES_LATCH_A_VALID 24'hffa02f
`define PES_LATCH_A_MAIN 24'h002027
`define PES_LATCH_A_OFF 24'h000008
`define PES_LATCH_A_CONN 24'hff8000
`define PES_LATCH_A_RST 24'h000000

`define PES_BLOCK_A_WMASK 24'hffa02f
`define PES_BLOCK_A_MAIN 24'hffa027
`define PES_BLOCK_A_OFF 24'h000008
`define PES_BLOCK_A_RST 24'hffa00f

`define PES_LIVE_A_VALID 24'h3e0028
`define PES_LIVE_A_CONN 24'h160000

`define PES_LATCH_B_VALID 24'h1ffffb
`define PES_LATCH_B_RTC 24'h0006e3
`define PES_LATCH_B_OFF 24'h000118
`define PES_LATCH_B_MAIN 24'h1ff800
`define PES_LATCH_B_RST 24'h000080

`define PES_SPI_CNT_W 6
`define PES_SPI_ADDR_CNT 6'h06
`define PES_SPI_DATA_CNT 6'h08
`define PES_SPI_LAST_CNT 6'h1f

`endif

// >>> pes_spi_slave.v
// Serial register port: frame shifter, address and write strobe
`timescale 1ns/100ps
`include "pes_event_regs.vh"

module pes_spi_slave (
	input wire clk_in,
	input wire reset_in,
	input wire sel_in,
	input wire sclk_rise_in,
	input wire sclk_fall_in,
	input wire mosi_in,
	input wire [`PES_DATA_W-1:0] rdata_in,
	output reg [`PES_ADDR_W-1:0] addr_out,
	output reg [`PES_DATA_W-1:0] wdata_out,
	output reg wr_out,
	output reg miso_out,
	output reg miso_oe_out
);
	reg [`PES_SPI_CNT_W-1:0] cnt_r;
	reg [30:0] in_sh_r;
	reg [`PES_DATA_W-1:0] out_sh_r;

	// Bit order: write flag, six address bits, spare, 24 data bits
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cnt_r <= 6'h00;
			in_sh_r <= 31'h00000000;
			out_sh_r <= 24'h000000;
			addr_out <= 6'h00;
			wdata_out <= 24'h000000;
			wr_out <= 1'b0;
			miso_out <= 1'b0;
			miso_oe_out <= 1'b0;
		end else begin
			wr_out <= 1'b0;
			if (!sel_in) begin
				cnt_r <= 6'h00;
				miso_out <= 1'b0;
				miso_oe_out <= 1'b0;
			end else begin
				if (sclk_rise_in && cnt_r <= `PES_SPI_LAST_CNT) begin
					in_sh_r <= {in_sh_r[29:0], mosi_in};
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == `PES_SPI_ADDR_CNT)
						addr_out <= {in_sh_r[4:0], mosi_in};
					if (cnt_r == `PES_SPI_LAST_CNT) begin
						wdata_out <= {in_sh_r[22:0], mosi_in};
						wr_out <= in_sh_r[30];
					end
				end
				if (sclk_fall_in) begin
					if (cnt_r == `PES_SPI_DATA_CNT) begin
						miso_out <= rdata_in[23];
						miso_oe_out <= 1'b1;
						out_sh_r <= {rdata_in[22:0], 1'b0};
					end else if (cnt_r > `PES_SPI_DATA_CNT) begin
						miso_out <= out_sh_r[23];
						out_sh_r <= {out_sh_r[22:0], 1'b0};
					end
				end
			end
		end
	end
endmodule

// >>> pes_event_ctrl.v
// Event latch, block and live banks behind the serial register port
`timescale 1ns/100ps
`include "pes_event_regs.vh"

module pes_event_ctrl (
	input wire ref_clk_in,
	input wire reset_in,
	input wire spi_sel_n_in,
	input wire spi_clk_in,
	input wire spi_mosi_in,
	input wire main_reset_n_in,
	input wire off_state_reset_n_in,
	input wire connector_block_reset_n_in,
	input wire backup_power_on_reset_n_in,
	input wire [23:0] bank_a_event_in,
	input wire [23:0] bank_b_event_in,
	input wire [23:0] live_a_in,
	output reg spi_miso_out,
	output reg spi_miso_oe_out,
	output reg irq_out
);
	// Rising edge of a synchronised level marks one event
	function [23:0] rise_of;
		input [23:0] now;
		input [23:0] was;
		begin
			rise_of = now & ~was;
		end
	endfunction

	// Write 1 clears, a new event wins over the clear
	function [23:0] w1c_next;
		input [23:0] cur;
		input [23:0] clr;
		input [23:0] set;
		input [23:0] valid;
		begin
			w1c_next = ((cur & ~clr) | set) & valid;
		end
	endfunction

	reg [3:0] spi_s1_r;
	reg [3:0] spi_s2_r;
	reg sclk_d_r;
	reg [3:0] rst_s1_r;
	reg [3:0] rst_s2_r;
	reg [23:0] evt_a_s1_r;
	reg [23:0] evt_a_s2_r;
	reg [23:0] evt_a_d_r;
	reg [23:0] evt_b_s1_r;
	reg [23:0] evt_b_s2_r;
	reg [23:0] evt_b_d_r;
	reg [23:0] live_s1_r;
	reg [23:0] live_s2_r;

	reg [23:0] latch_a_r;
	reg [23:0] latch_a_nxt;
	reg [23:0] block_a_r;
	reg [23:0] block_a_nxt;
	reg [23:0] live_a_r;
	reg [23:0] live_a_nxt;
	reg [23:0] latch_b_r;
	reg [23:0] latch_b_nxt;
	reg [23:0] rdata;

	wire sel;
	wire sclk;
	wire mosi;
	wire sclk_rise;
	wire sclk_fall;
	wire main_clr;
	wire off_clr;
	wire conn_clr;
	wire rtc_clr;
	wire [23:0] set_a;
	wire [23:0] set_b;
	wire [5:0] reg_addr;
	wire [23:0] wdata;
	wire wr;
	wire miso;
	wire miso_oe;
	wire [23:0] clr_a;
	wire [23:0] clr_b;

	// Two flip-flops on every pin before any logic reads it
	always @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			spi_s1_r <= 4'h1;
			spi_s2_r <= 4'h1;
			sclk_d_r <= 1'b0;
			rst_s1_r <= 4'hf;
			rst_s2_r <= 4'hf;
		end else begin
			spi_s1_r <= {spi_clk_in, spi_mosi_in, 1'b0, spi_sel_n_in};
			spi_s2_r <= spi_s1_r;
			sclk_d_r <= spi_s2_r[3];
			rst_s1_r <= {main_reset_n_in, off_state_reset_n_in,
				connector_block_reset_n_in, backup_power_on_reset_n_in};
			rst_s2_r <= rst_s1_r;
		end
	end

	always @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			evt_a_s1_r <= 24'h000000;
			evt_a_s2_r <= 24'h000000;
			evt_a_d_r <= 24'h000000;
			evt_b_s1_r <= 24'h000000;
			evt_b_s2_r <= 24'h000000;
			evt_b_d_r <= 24'h000000;
			live_s1_r <= 24'h000000;
			live_s2_r <= 24'h000000;
		end else begin
			evt_a_s1_r <= bank_a_event_in;
			evt_a_s2_r <= evt_a_s1_r;
			evt_a_d_r <= evt_a_s2_r;
			evt_b_s1_r <= bank_b_event_in;
			evt_b_s2_r <= evt_b_s1_r;
			evt_b_d_r <= evt_b_s2_r;
			live_s1_r <= live_a_in;
			live_s2_r <= live_s1_r;
		end
	end

	assign sel = ~spi_s2_r[0];
	assign mosi = spi_s2_r[2];
	assign sclk = spi_s2_r[3];
	assign sclk_rise = sclk & ~sclk_d_r;
	assign sclk_fall = ~sclk & sclk_d_r;
	assign main_clr = ~rst_s2_r[3];
	assign off_clr = ~rst_s2_r[2];
	assign conn_clr = ~rst_s2_r[1];
	assign rtc_clr = ~rst_s2_r[0];

	assign set_a = rise_of(evt_a_s2_r, evt_a_d_r) & `PES_LATCH_A_VALID;
	assign set_b = rise_of(evt_b_s2_r, evt_b_d_r) & `PES_LATCH_B_VALID;

	pes_spi_slave u_spi (
		.clk_in(ref_clk_in),
		.reset_in(reset_in),
		.sel_in(sel),
		.sclk_rise_in(sclk_rise),
		.sclk_fall_in(sclk_fall),
		.mosi_in(mosi),
		.rdata_in(rdata),
		.addr_out(reg_addr),
		.wdata_out(wdata),
		.wr_out(wr),
		.miso_out(miso),
		.miso_oe_out(miso_oe)
	);

	assign clr_a = (wr && reg_addr == `PES_OFF_LATCH_A) ?
		wdata : 24'h000000;
	assign clr_b = (wr && reg_addr == `PES_OFF_LATCH_B) ?
		wdata : 24'h000000;

	// Bank A latches, each group with its own clearing reset
	always @* begin
		latch_a_nxt = w1c_next(latch_a_r, clr_a, set_a,
			`PES_LATCH_A_VALID);
		if (main_clr)
			latch_a_nxt = latch_a_nxt & ~`PES_LATCH_A_MAIN;
		if (off_clr)
			latch_a_nxt = latch_a_nxt & ~`PES_LATCH_A_OFF;
		if (conn_clr)
			latch_a_nxt = latch_a_nxt & ~`PES_LATCH_A_CONN;
	end

	// Bank B latches; clock-domain reset flag returns to 1
	always @* begin
		latch_b_nxt = w1c_next(latch_b_r, clr_b, set_b,
			`PES_LATCH_B_VALID);
		if (rtc_clr)
			latch_b_nxt = (latch_b_nxt & ~`PES_LATCH_B_RTC) |
				`PES_LATCH_B_RST;
		if (off_clr)
			latch_b_nxt = latch_b_nxt & ~`PES_LATCH_B_OFF;
		if (main_clr)
			latch_b_nxt = latch_b_nxt & ~`PES_LATCH_B_MAIN;
	end

	// Block bits: writable positions only, reserved read 0
	always @* begin
		block_a_nxt = block_a_r;
		if (wr && reg_addr == `PES_OFF_BLOCK_A)
			block_a_nxt = wdata & `PES_BLOCK_A_WMASK;
		if (main_clr)
			block_a_nxt = (block_a_nxt & ~`PES_BLOCK_A_MAIN) |
				(`PES_BLOCK_A_RST & `PES_BLOCK_A_MAIN);
		if (off_clr)
			block_a_nxt = (block_a_nxt & ~`PES_BLOCK_A_OFF) |
				(`PES_BLOCK_A_RST & `PES_BLOCK_A_OFF);
	end

	// Live bank follows its inputs; done bits held low in connector reset
	always @* begin
		live_a_nxt = live_s2_r & `PES_LIVE_A_VALID;
		if (conn_clr)
			live_a_nxt = live_a_nxt & ~`PES_LIVE_A_CONN;
	end

	always @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			latch_a_r <= `PES_LATCH_A_RST;
			latch_b_r <= `PES_LATCH_B_RST;
			block_a_r <= `PES_BLOCK_A_RST;
			live_a_r <= 24'h000000;
		end else begin
			latch_a_r <= latch_a_nxt;
			latch_b_r <= latch_b_nxt;
			block_a_r <= block_a_nxt;
			live_a_r <= live_a_nxt;
		end
	end

	// Read mux; unmapped addresses read zero
	always @* begin
		case (reg_addr)
			`PES_OFF_LATCH_A: rdata = latch_a_r;
			`PES_OFF_BLOCK_A: rdata = block_a_r;
			`PES_OFF_LIVE_A: rdata = live_a_r;
			`PES_OFF_LATCH_B: rdata = latch_b_r;
			default: rdata = 24'h000000;
		endcase
	end

	always @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			irq_out <= 1'b0;
			spi_miso_out <= 1'b0;
			spi_miso_oe_out <= 1'b0;
		end else begin
			irq_out <= |(latch_a_r & ~block_a_r);
			spi_miso_out <= miso;
			spi_miso_oe_out <= miso_oe;
		end
	end
endmodule

// >>> pes_event_ctrl_asserts.sv
// Port checker for the event controller
`timescale 1ns/100ps
module pes_chk (
	input wire ref_clk_in,
	input wire reset_in,
	input wire spi_sel_n_in,
	input wire main_reset_n_in,
	input wire off_state_reset_n_in,
	input wire connector_block_reset_n_in,
	input wire [23:0] bank_a_event_in,
	input wire spi_miso_out,
	input wire spi_miso_oe_out,
	input wire irq_out
);
	reg [3:0] quiet_r;
	wire calm = spi_sel_n_in && main_reset_n_in && off_state_reset_n_in;
	wire dom_low = !main_reset_n_in && !off_state_reset_n_in;
	always @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in)
			quiet_r <= 4'h0;
		else if (!calm || !connector_block_reset_n_in ||
		    $changed(bank_a_event_in))
			quiet_r <= 4'h0;
		else if (quiet_r != 4'hf)
			quiet_r <= quiet_r + 4'h1;
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	a_miso_idle_low: assert property (
		!spi_miso_oe_out |-> !spi_miso_out)
		else $error("miso high while not driving");
	a_oe_sel_off: assert property (
		spi_sel_n_in [*8] |-> !spi_miso_oe_out)
		else $error("miso enabled without select");
	a_oe_rise_sel: assert property (
		$rose(spi_miso_oe_out) |-> !$past(spi_sel_n_in, 3))
		else $error("miso enabled too early");
	a_irq_ovp_event: assert property (
		($rose(bank_a_event_in[5]) && quiet_r > 4'h8) |->
		##[4:7] irq_out)
		else $error("overvoltage did not raise irq");
	a_irq_not_early: assert property (
		($rose(bank_a_event_in[5]) && !irq_out && quiet_r > 4'h8) |=>
		!irq_out [*2])
		else $error("irq rose before event latched");
	a_irq_dom_clear: assert property (
		(dom_low && !connector_block_reset_n_in) [*6] |-> !irq_out)
		else $error("irq held through domain clears");
	a_irq_stable_quiet: assert property (
		quiet_r > 4'h8 |-> $stable(irq_out))
		else $error("irq moved without a cause");
	a_irq_fall_quiet: assert property (
		$fell(irq_out) |-> quiet_r < 4'h9)
		else $error("irq fell without a cause");
	c_irq_set: cover property (irq_out && quiet_r == 4'hf);
	c_miso_on: cover property ($rose(spi_miso_oe_out));
	c_irq_fall: cover property ($fell(irq_out));
endmodule
bind pes_event_ctrl pes_chk u_chk (.ref_clk_in(ref_clk_in),
	.reset_in(reset_in), .spi_sel_n_in(spi_sel_n_in),
	.main_reset_n_in(main_reset_n_in),
	.off_state_reset_n_in(off_state_reset_n_in),
	.connector_block_reset_n_in(connector_block_reset_n_in),
	.bank_a_event_in(bank_a_event_in), .spi_miso_out(spi_miso_out),
	.spi_miso_oe_out(spi_miso_oe_out), .irq_out(irq_out));

// >>> pes_host_model.sv
// Host model sending serial register frames
`timescale 1ns/100ps
module pes_host_model (
	input wire ref_clk_in,
	input wire miso_in,
	output reg sel_n_out,
	output reg sclk_out,
	output reg mosi_out
);
	reg [23:0] rd_r;
	initial begin
		sel_n_out = 1'b1;
		sclk_out = 1'b0;
		mosi_out = 1'b0;
	end
	task half;
		repeat (8) @(negedge ref_clk_in);
	endtask
	// One frame: write flag, address, spare 0, 24 data bits, MSB first
	task xfer(input wr, input [5:0] a, input [23:0] d);
		reg [31:0] f;
		integer i;
		begin
			f = {wr, a, 1'b0, d};
			sel_n_out = 1'b0;
			for (i = 31; i >= 0; i = i - 1) begin
				mosi_out = f[i];
				half;
				if (i < 24)
					rd_r[i] = miso_in;
				sclk_out = 1'b1;
				half;
				sclk_out = 1'b0;
			end
			half;
			sel_n_out = 1'b1;
			mosi_out = ~mosi_out;
			half;
		end
	endtask
endmodule

// >>> tb.sv
// Testbench for the event controller
`timescale 1ns/100ps
module tb;
	reg ref_clk_in, reset_in;
	reg [3:0] dom_n;
	reg [23:0] ev_a, ev_b, live;
	wire sel_n, sclk, mosi, miso, oe, irq;
	integer err_total, tests_run;
	pes_event_ctrl uut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.spi_sel_n_in(sel_n), .spi_clk_in(sclk), .spi_mosi_in(mosi),
		.main_reset_n_in(dom_n[2]), .off_state_reset_n_in(dom_n[1]),
		.connector_block_reset_n_in(dom_n[0]),
		.backup_power_on_reset_n_in(dom_n[3]), .bank_a_event_in(ev_a),
		.bank_b_event_in(ev_b), .live_a_in(live), .spi_miso_out(miso),
		.spi_miso_oe_out(oe), .irq_out(irq));
	pes_host_model host (.ref_clk_in(ref_clk_in), .miso_in(miso),
		.sel_n_out(sel_n), .sclk_out(sclk), .mosi_out(mosi));
	initial begin
		ref_clk_in = 1'b0;
		forever #25 ref_clk_in = ~ref_clk_in;
	end
	task tally_and_finish;
		begin
			$display("comparisons %0d mismatches %0d",
				tests_run, err_total);
			if (err_total == 0 && tests_run > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task miss(input [23:0] got, input [23:0] exp);
		begin
			err_total = err_total + 1;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk_reg(input [5:0] a, input [23:0] exp);
		begin
			host.xfer(1'b0, a, 24'h0);
			tests_run = tests_run + 1;
			if (host.rd_r !== exp)
				miss(host.rd_r, exp);
		end
	endtask
	task chk_pin(input got, input exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp)
				miss({23'h0, got}, {23'h0, exp});
		end
	endtask
	task wt(input integer n);
		repeat (n) @(negedge ref_clk_in);
	endtask
	// Pulse the chosen domain clears low
	task dom(input [3:0] low);
		begin
			dom_n = ~low;
			wt(6);
			dom_n = 4'hf;
			wt(6);
		end
	endtask
	task t_reset;
		begin
			chk_reg(6'h00, 24'h000000);
			chk_reg(6'h01, 24'hffa00f);
			chk_reg(6'h02, 24'h3e0028);
			host.xfer(1'b1, 6'h02, 24'h000000);
			live = 24'h000008;
			chk_reg(6'h02, 24'h000008);
			chk_reg(6'h03, 24'h000080);
			chk_reg(6'h05, 24'h000000);
			chk_pin(irq, 1'b0);
			$display("test reset done");
		end
	endtask
	task t_bank_a;
		begin
			wt(4);
			ev_a = 24'hffffff;
			wt(12);
			chk_pin(irq, 1'b1);
			ev_a = 24'h0;
			wt(12);
			chk_reg(6'h00, 24'hffa02f);
			host.xfer(1'b1, 6'h00, 24'h000021);
			chk_reg(6'h00, 24'hffa00e);
			chk_pin(irq, 1'b0);
			host.xfer(1'b1, 6'h01, 24'h000000);
			chk_reg(6'h01, 24'h000000);
			chk_pin(irq, 1'b1);
			host.xfer(1'b1, 6'h01, 24'hffffdf);
			chk_reg(6'h01, 24'hffa00f);
			dom(4'b0001);
			chk_reg(6'h00, 24'h00200e);
			dom(4'b0010);
			chk_reg(6'h00, 24'h002006);
			dom(4'b0111);
			chk_reg(6'h00, 24'h000000);
			$display("test bank a done");
		end
	endtask
	task t_bank_b;
		begin
			ev_b = 24'hffffff;
			wt(12);
			ev_b = 24'h0;
			wt(12);
			chk_reg(6'h03, 24'h1ffffb);
			dom(4'b0100);
			chk_reg(6'h03, 24'h0007fb);
			host.xfer(1'b1, 6'h03, 24'h0006e3);
			chk_reg(6'h03, 24'h000118);
			dom(4'b1000);
			chk_reg(6'h03, 24'h000198);
			$display("test bank b done");
		end
	endtask
	// Live bank with the connector clear held low, then released
	task t_live;
		begin
			live = 24'hffffff;
			dom_n = 4'he;
			wt(6);
			chk_reg(6'h02, 24'h280028);
			dom_n = 4'hf;
			wt(6);
			chk_reg(6'h02, 24'h3e0028);
			$display("test live done");
		end
	endtask
	initial begin
		err_total = 0;
		tests_run = 0;
		reset_in = 1'b1;
		dom_n = 4'hf;
		ev_a = 24'h0;
		ev_b = 24'h0;
		live = 24'hffffff;
		repeat (6) @(negedge ref_clk_in);
		reset_in = 1'b0;
		wt(4);
		t_reset;
		t_bank_a;
		t_bank_b;
		t_live;
		tally_and_finish;
	end
	initial begin
		repeat (60000) @(posedge ref_clk_in);
		err_total = err_total + 1;
		$display("mismatch %0t watchdog expired", $time);
		tally_and_finish;
	end
endmodule
